// file: shared/dbds_map.vh
// register offsets, field positions and codes of the descriptor base and status block
`ifndef DBDS_MAP_VH
`define DBDS_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DBDS_OFS_RX_BASE     8'h18
`define DBDS_OFS_TX_BASE     8'h20
`define DBDS_OFS_STATUS      8'h28

// ----------------------------------------
// reset values
// ----------------------------------------
`define DBDS_RST_BASE        32'h00000000
`define DBDS_RST_KIND        3'h0

// ----------------------------------------
// status field positions
// ----------------------------------------
`define DBDS_BIT_TX_DONE     0
`define DBDS_BIT_TX_MISSING  2
`define DBDS_BIT_RX_DONE     6
`define DBDS_BIT_BUS_FAULT   13
`define DBDS_BIT_NORMAL_SUM  16
`define DBDS_CLR_MSB         13

// ----------------------------------------
// process state codes
// ----------------------------------------
`define DBDS_TX_STOP         3'h0
`define DBDS_TX_FETCH        3'h1
`define DBDS_TX_SETUP        3'h2
`define DBDS_TX_MOVE         3'h3
`define DBDS_TX_CLOSE        3'h4
`define DBDS_TX_WAIT         3'h5
`define DBDS_TX_STAT         3'h6
`define DBDS_TX_SUSP         3'h7
`define DBDS_RX_STOP         3'h0
`define DBDS_RX_FETCH        3'h1
`define DBDS_RX_WAIT         3'h2
`define DBDS_RX_MOVE         3'h3
`define DBDS_RX_STAT         3'h5
`define DBDS_RX_SUSP         3'h6
`define DBDS_RX_PURGE        3'h7

// ----------------------------------------
// bus error kinds and descriptor stride
// ----------------------------------------
`define DBDS_ERR_PARITY      3'h0
`define DBDS_ERR_MABORT      3'h1
`define DBDS_ERR_SABORT      3'h2
`define DBDS_DESC_BYTES      32'h00000010

`endif

// file: rtl/dbds_fifo.v
// data fifo with registered read port
`timescale 1ns/10ps
module dbds_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             clock,
  input  wire             rstn,
  // fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready_r,
  // drain side
  output reg  [WIDTH-1:0] out_data_r,
  output reg              out_valid_r,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  reg [AW:0]      count_nxt;
  wire            push;
  wire            pop;

  // ----------------------------------------
  // push and pop
  // ----------------------------------------
  assign push = in_valid && in_ready_r;
  assign pop  = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready);

  always @*
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  always @(posedge clock)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= {(AW+1){1'b0}};
      in_ready_r  <= 1'b0;
      out_valid_r <= 1'b0;
      out_data_r  <= {WIDTH{1'b0}};
    end
    else
    begin
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt < DEPTH[AW:0]);
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
      begin
        out_data_r  <= mem_r[rd_ptr_r];
        out_valid_r <= 1'b1;
        rd_ptr_r    <= rd_ptr_r + 1'b1;
      end
      else if (out_ready)
        out_valid_r <= 1'b0;
    end
  end

endmodule // dbds_fifo

// file: rtl/dbds_top.v
// descriptor chain bases, process sequencers and network status report
// Overview of operation
// - the receive chain base is a 32-bit host-written value that resets to zero.
// - a receive poll after writing the base fetches the descriptor at that base.
// - the transmit chain base is a 32-bit host-written value that resets to zero.
// - a transmit poll after writing the base fetches the descriptor at that base.
// - writing one to status bits 13 to 0 clears them and writing zero keeps them.
// - bits 25 to 23 give the fatal bus error kind, valid while the fault flag is set.
// - bits 22 to 20 give the transmit process state code.
// - bits 19 to 17 give the receive process state code.
// - bit 16 is set whenever any of the three normal conditions is present.
// - the normal conditions are transmit done, transmit buffer missing, receive done.
`timescale 1ns/10ps
`include "dbds_map.vh"
module dbds_top (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata_r,
  output reg         reg_rvalid_r,
  // poll commands
  input  wire        tx_poll,
  input  wire        rx_poll,
  // transmit descriptor fetch
  output reg         tx_fetch_req_r,
  output reg  [31:0] tx_chain_base_r,
  input  wire        tx_fetch_ack,
  input  wire        tx_fetch_avail,
  input  wire        tx_fetch_setup,
  input  wire        tx_step,
  // receive descriptor fetch
  output reg         rx_fetch_req_r,
  output reg  [31:0] rx_chain_base_r,
  input  wire        rx_fetch_ack,
  input  wire        rx_fetch_avail,
  input  wire        rx_frame,
  input  wire        rx_step,
  // bus error report
  input  wire        bus_fault_evt,
  input  wire [2:0]  bus_fault_code,
  // memory read data stream
  input  wire [31:0] mem_rdata,
  input  wire        mem_rvalid,
  output wire        mem_rready,
  output wire [31:0] data_out,
  output wire        data_out_valid,
  input  wire        data_out_ready
);

  localparam TX_STOP  = 8'h01;
  localparam TX_FETCH = 8'h02;
  localparam TX_SETUP = 8'h04;
  localparam TX_MOVE  = 8'h08;
  localparam TX_CLOSE = 8'h10;
  localparam TX_WAIT  = 8'h20;
  localparam TX_STAT  = 8'h40;
  localparam TX_SUSP  = 8'h80;
  localparam RX_STOP  = 7'h01;
  localparam RX_FETCH = 7'h02;
  localparam RX_WAIT  = 7'h04;
  localparam RX_MOVE  = 7'h08;
  localparam RX_STAT  = 7'h10;
  localparam RX_SUSP  = 7'h20;
  localparam RX_PURGE = 7'h40;

  reg  [7:0]  tx_state_r;
  reg  [7:0]  tx_state_nxt;
  reg  [6:0]  rx_state_r;
  reg  [6:0]  rx_state_nxt;
  reg  [2:0]  tx_process_state;
  reg  [2:0]  rx_process_state;
  reg  [13:0] flags_r;
  reg  [13:0] flags_set;
  wire [13:0] flags_clr;
  reg  [2:0]  bus_error_kind_r;
  reg         normal_irq_summary_r;
  reg  [31:0] status_word;
  wire        wr_rx_base;
  wire        wr_tx_base;
  wire        wr_status;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr_rx_base = reg_wr && (reg_addr == `DBDS_OFS_RX_BASE);
  assign wr_tx_base = reg_wr && (reg_addr == `DBDS_OFS_TX_BASE);
  assign wr_status  = reg_wr && (reg_addr == `DBDS_OFS_STATUS);
  assign flags_clr  = wr_status ? reg_wdata[`DBDS_CLR_MSB:0] : 14'h0000;

  // ----------------------------------------
  // transmit sequencer
  // ----------------------------------------
  always @*
  begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      TX_STOP, TX_SUSP:
        if (tx_poll)
          tx_state_nxt = TX_FETCH;
      TX_FETCH:
        if (tx_fetch_ack)
          tx_state_nxt = !tx_fetch_avail ? TX_SUSP : (tx_fetch_setup ? TX_SETUP : TX_MOVE);
      TX_SETUP:
        if (tx_step)
          tx_state_nxt = TX_STAT;
      TX_MOVE:
        if (tx_step)
          tx_state_nxt = TX_CLOSE;
      TX_CLOSE:
        if (tx_step)
          tx_state_nxt = TX_WAIT;
      TX_WAIT:
        if (tx_step)
          tx_state_nxt = TX_STAT;
      TX_STAT:
        if (tx_step)
          tx_state_nxt = TX_FETCH;
      default:
        tx_state_nxt = TX_STOP;
    endcase
  end
  always @*
  begin
    case (tx_state_r)
      TX_FETCH: tx_process_state = `DBDS_TX_FETCH;
      TX_SETUP: tx_process_state = `DBDS_TX_SETUP;
      TX_MOVE:  tx_process_state = `DBDS_TX_MOVE;
      TX_CLOSE: tx_process_state = `DBDS_TX_CLOSE;
      TX_WAIT:  tx_process_state = `DBDS_TX_WAIT;
      TX_STAT:  tx_process_state = `DBDS_TX_STAT;
      TX_SUSP:  tx_process_state = `DBDS_TX_SUSP;
      default:  tx_process_state = `DBDS_TX_STOP;
    endcase
  end

  // ----------------------------------------
  // receive sequencer
  // ----------------------------------------
  always @*
  begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      RX_STOP:
        if (rx_poll)
          rx_state_nxt = RX_FETCH;
      RX_SUSP:
        if (rx_poll)
          rx_state_nxt = RX_FETCH;
        else if (rx_frame)
          rx_state_nxt = RX_PURGE;
      RX_FETCH:
        if (rx_fetch_ack)
          rx_state_nxt = rx_fetch_avail ? RX_WAIT : RX_SUSP;
      RX_WAIT:
        if (rx_frame)
          rx_state_nxt = RX_MOVE;
      RX_MOVE:
        if (rx_step)
          rx_state_nxt = RX_STAT;
      RX_STAT:
        if (rx_step)
          rx_state_nxt = RX_FETCH;
      RX_PURGE:
        if (rx_step)
          rx_state_nxt = RX_SUSP;
      default:
        rx_state_nxt = RX_STOP;
    endcase
  end
  always @*
  begin
    case (rx_state_r)
      RX_FETCH: rx_process_state = `DBDS_RX_FETCH;
      RX_WAIT:  rx_process_state = `DBDS_RX_WAIT;
      RX_MOVE:  rx_process_state = `DBDS_RX_MOVE;
      RX_STAT:  rx_process_state = `DBDS_RX_STAT;
      RX_SUSP:  rx_process_state = `DBDS_RX_SUSP;
      RX_PURGE: rx_process_state = `DBDS_RX_PURGE;
      default:  rx_process_state = `DBDS_RX_STOP;
    endcase
  end

  // ----------------------------------------
  // status events
  // ----------------------------------------
  always @*
  begin
    flags_set = 14'h0000;
    flags_set[`DBDS_BIT_TX_DONE]    = (tx_state_r == TX_STAT) && tx_step;
    flags_set[`DBDS_BIT_TX_MISSING] = (tx_state_r == TX_FETCH) && tx_fetch_ack
                                      && !tx_fetch_avail;
    flags_set[`DBDS_BIT_RX_DONE]    = (rx_state_r == RX_STAT) && rx_step;
    flags_set[`DBDS_BIT_BUS_FAULT]  = bus_fault_evt;
  end

  always @*
  begin
    status_word = 32'h00000000;
    status_word[25:23] = bus_error_kind_r;
    status_word[22:20] = tx_process_state;
    status_word[19:17] = rx_process_state;
    status_word[`DBDS_BIT_NORMAL_SUM] = normal_irq_summary_r;
    status_word[`DBDS_CLR_MSB:0] = flags_r;
  end

  // ----------------------------------------
  // state, pointers and flags
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      tx_state_r           <= TX_STOP;
      rx_state_r           <= RX_STOP;
      tx_chain_base_r      <= `DBDS_RST_BASE;
      rx_chain_base_r      <= `DBDS_RST_BASE;
      tx_fetch_req_r       <= 1'b0;
      rx_fetch_req_r       <= 1'b0;
      flags_r              <= 14'h0000;
      bus_error_kind_r     <= `DBDS_RST_KIND;
      normal_irq_summary_r <= 1'b0;
    end
    else
    begin
      tx_state_r <= tx_state_nxt;
      rx_state_r <= rx_state_nxt;
      tx_fetch_req_r <= (tx_state_nxt == TX_FETCH) && !(tx_fetch_req_r && tx_fetch_ack);
      rx_fetch_req_r <= (rx_state_nxt == RX_FETCH) && !(rx_fetch_req_r && rx_fetch_ack);
      if (wr_tx_base)
        tx_chain_base_r <= reg_wdata;
      else if ((tx_state_r == TX_STAT) && tx_step)
        tx_chain_base_r <= tx_chain_base_r + `DBDS_DESC_BYTES;
      if (wr_rx_base)
        rx_chain_base_r <= reg_wdata;
      else if ((rx_state_r == RX_STAT) && rx_step)
        rx_chain_base_r <= rx_chain_base_r + `DBDS_DESC_BYTES;
      flags_r <= (flags_r & ~flags_clr) | flags_set;
      if (bus_fault_evt)
        bus_error_kind_r <= bus_fault_code;
      normal_irq_summary_r <= flags_set[`DBDS_BIT_TX_DONE] | flags_set[`DBDS_BIT_TX_MISSING]
        | flags_set[`DBDS_BIT_RX_DONE]
        | (flags_r[`DBDS_BIT_TX_DONE] & ~flags_clr[`DBDS_BIT_TX_DONE])
        | (flags_r[`DBDS_BIT_TX_MISSING] & ~flags_clr[`DBDS_BIT_TX_MISSING])
        | (flags_r[`DBDS_BIT_RX_DONE] & ~flags_clr[`DBDS_BIT_RX_DONE]);
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      reg_rdata_r  <= 32'h00000000;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `DBDS_OFS_RX_BASE: reg_rdata_r <= rx_chain_base_r;
          `DBDS_OFS_TX_BASE: reg_rdata_r <= tx_chain_base_r;
          `DBDS_OFS_STATUS:  reg_rdata_r <= status_word;
          default:           reg_rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // memory data buffer
  // ----------------------------------------
  dbds_fifo #(
    .WIDTH (32),
    .DEPTH (32),
    .AW    (5)
  ) u_fifo (
    .clock       (clock),
    .rstn        (rstn),
    .in_data     (mem_rdata),
    .in_valid    (mem_rvalid),
    .in_ready_r  (mem_rready),
    .out_data_r  (data_out),
    .out_valid_r (data_out_valid),
    .out_ready   (data_out_ready)
  );

endmodule // dbds_top

// file: test/dbds_monitor.sv
// checker of the descriptor base and status block ports
`timescale 1ns/10ps
`include "dbds_map.vh"
module dbds_monitor (
  // clock and reset
  input wire        clock,
  input wire        rstn,
  // register port
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata_r,
  input wire        reg_rvalid_r,
  // fetch and fault
  input wire        tx_fetch_req_r,
  input wire        tx_fetch_ack,
  input wire [31:0] tx_chain_base_r,
  input wire        rx_fetch_req_r,
  input wire        rx_fetch_ack,
  input wire [31:0] rx_chain_base_r,
  input wire        bus_fault_evt,
  input wire [2:0]  bus_fault_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire st_rd = reg_rd && reg_addr == `DBDS_OFS_STATUS;
  wire st_wr = reg_wr && reg_addr == `DBDS_OFS_STATUS;
  AST_BASE_RST:
  assert property ($rose(rstn) |-> rx_chain_base_r == 32'h0 && tx_chain_base_r == 32'h0)
    else $error("base not zero after reset");
  AST_RX_BASE_WR:
  assert property (reg_wr && reg_addr == `DBDS_OFS_RX_BASE |=> rx_chain_base_r == $past(reg_wdata))
    else $error("rx base not loaded");
  AST_TX_BASE_WR:
  assert property (reg_wr && reg_addr == `DBDS_OFS_TX_BASE |=> tx_chain_base_r == $past(reg_wdata))
    else $error("tx base not loaded");
  AST_TX_REQ_HOLD:
  assert property (tx_fetch_req_r |=> tx_fetch_req_r != $past(tx_fetch_ack))
    else $error("tx fetch request not held until ack");
  AST_RX_REQ_HOLD:
  assert property (rx_fetch_req_r |=> rx_fetch_req_r != $past(rx_fetch_ack))
    else $error("rx fetch request not held until ack");
  AST_READ_ANSWER:
  assert property (reg_rvalid_r == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  AST_SUMMARY:
  assert property (st_rd |=> reg_rdata_r[16] == (reg_rdata_r[0] | reg_rdata_r[2] | reg_rdata_r[6]))
    else $error("summary flag disagrees with normal flags");
  AST_FAULT_KIND:
  assert property (bus_fault_evt ##2 st_rd |=>
    reg_rdata_r[13] && reg_rdata_r[25:23] == $past(bus_fault_code, 3))
    else $error("bus fault flag or kind wrong");
  AST_FAULT_CLEAR:
  assert property (st_wr && reg_wdata[13] && !bus_fault_evt ##1 !bus_fault_evt
    ##1 st_rd && !bus_fault_evt |=> !reg_rdata_r[13])
    else $error("write one did not clear flag");
  cover property (tx_fetch_req_r && tx_fetch_ack);
  cover property (rx_fetch_req_r && rx_fetch_ack);
  cover property (bus_fault_evt ##2 st_rd);
endmodule // dbds_monitor

bind dbds_top dbds_monitor i_dbds_monitor (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
  .reg_rvalid_r(reg_rvalid_r), .tx_fetch_req_r(tx_fetch_req_r), .tx_fetch_ack(tx_fetch_ack),
  .tx_chain_base_r(tx_chain_base_r), .rx_fetch_req_r(rx_fetch_req_r),
  .rx_fetch_ack(rx_fetch_ack), .rx_chain_base_r(rx_chain_base_r),
  .bus_fault_evt(bus_fault_evt), .bus_fault_code(bus_fault_code));

// file: test/dbds_partner.sv
// host memory model answering descriptor fetches
`timescale 1ns/10ps
module dbds_partner (
  // clock and reset
  input  wire       clock,
  input  wire       rstn,
  // fetch request and chosen descriptor content
  input  wire       fetch_req,
  input  wire       own,
  input  wire       setup,
  // answer
  output reg        ack_r,
  output reg        own_r,
  output reg        setup_r
);
  reg  [1:0] wait_r;
  wire       take;

  assign take = !ack_r && fetch_req && (wait_r == 2'h0);

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      ack_r  <= 1'b0;
      wait_r <= 2'h1;
    end
    else if (ack_r)
      ack_r <= 1'b0;
    else if (take)
    begin
      ack_r  <= 1'b1;
      wait_r <= 2'h1 + 2'($urandom % 3);
    end
    else if (fetch_req)
      wait_r <= wait_r - 2'h1;
  end

  always @(posedge clock)
  begin
    if (!rstn)
    begin
      own_r   <= 1'b0;
      setup_r <= 1'b0;
    end
    else if (take)
    begin
      own_r   <= own;
      setup_r <= setup;
    end
    else
    begin
      own_r   <= ~own_r;
      setup_r <= ~setup_r;
    end
  end
endmodule // dbds_partner

// file: test/dbds_top_test.sv
// self-checking bench of the descriptor base and status block
`timescale 1ns/10ps
`include "dbds_map.vh"
module dbds_top_test;
  reg         clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0, mem_rdata = 32'h0, tb, rb;
  reg         tx_poll = 1'b0, rx_poll = 1'b0, tx_step = 1'b0, rx_step = 1'b0;
  reg         rx_frame = 1'b0, bus_fault_evt = 1'b0, mem_rvalid = 1'b0;
  reg         data_out_ready = 1'b0, p_own = 1'b1, p_setup = 1'b0;
  reg  [2:0]  bus_fault_code = 3'h0, kd = 3'h0;
  reg  [13:0] fl = 14'h0;
  wire [31:0] reg_rdata_r, tx_chain_base_r, rx_chain_base_r, data_out;
  wire        reg_rvalid_r, tx_fetch_req_r, tx_fetch_ack, tx_fetch_avail, tx_fetch_setup;
  wire        rx_fetch_req_r, rx_fetch_ack, rx_fetch_avail, mem_rready, data_out_valid;
  int         bad_count = 0, cmp_count = 0, i, n;
  logic [31:0] rq[$], dq[$];
  always #5 clock = ~clock;
  dbds_top i_dbds_top (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .tx_poll(tx_poll), .rx_poll(rx_poll),
    .tx_fetch_req_r(tx_fetch_req_r), .tx_chain_base_r(tx_chain_base_r),
    .tx_fetch_ack(tx_fetch_ack), .tx_fetch_avail(tx_fetch_avail),
    .tx_fetch_setup(tx_fetch_setup), .tx_step(tx_step), .rx_fetch_req_r(rx_fetch_req_r),
    .rx_chain_base_r(rx_chain_base_r), .rx_fetch_ack(rx_fetch_ack),
    .rx_fetch_avail(rx_fetch_avail), .rx_frame(rx_frame), .rx_step(rx_step),
    .bus_fault_evt(bus_fault_evt), .bus_fault_code(bus_fault_code), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .mem_rready(mem_rready), .data_out(data_out),
    .data_out_valid(data_out_valid), .data_out_ready(data_out_ready));
  dbds_partner i_dbds_partner_tx (.clock(clock), .rstn(rstn), .fetch_req(tx_fetch_req_r),
    .own(p_own), .setup(p_setup), .ack_r(tx_fetch_ack), .own_r(tx_fetch_avail),
    .setup_r(tx_fetch_setup));
  dbds_partner i_dbds_partner_rx (.clock(clock), .rstn(rstn), .fetch_req(rx_fetch_req_r),
    .own(p_own), .setup(p_setup), .ack_r(rx_fetch_ack), .own_r(rx_fetch_avail),
    .setup_r());
  task end_sim;
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (reg_rvalid_r === 1'b1)
    begin
      if (rq.size())
        chk(reg_rdata_r, rq.pop_front());
      else
        chk(32'h1, 32'h0);
    end
    if (data_out_valid === 1'b1 && data_out_ready === 1'b1)
    begin
      if (dq.size())
        chk(data_out, dq.pop_front());
      else
        chk(32'h1, 32'h0);
    end
  end
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task st(input [2:0] t, input [2:0] r);
    rd(`DBDS_OFS_STATUS, {6'h00, kd, t, r, fl[0] | fl[2] | fl[6], 2'h0, fl});
  endtask
  task pt(input int w);
    @(posedge clock);
    case (w)
      0: tx_poll <= 1'b1;
      1: rx_poll <= 1'b1;
      2: tx_step <= 1'b1;
      3: rx_step <= 1'b1;
      4: rx_frame <= 1'b1;
      default: bus_fault_evt <= 1'b1;
    endcase
    @(posedge clock);
    {tx_poll, rx_poll, tx_step, rx_step, rx_frame, bus_fault_evt} <= 6'h00;
  endtask
  task wt(input bit t);
    #1;
    for (n = 0; n < 20 && (t ? tx_fetch_req_r : rx_fetch_req_r) !== 1'b0; n++)
    begin
      @(posedge clock);
      #1;
    end
    if (n == 20)
    begin
      chk(32'h1, 32'h0);
      end_sim;
    end
  endtask
  initial
  begin
    void'($urandom(18886));
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    chk(tx_chain_base_r, `DBDS_RST_BASE);
    chk(rx_chain_base_r, `DBDS_RST_BASE);
    st(3'h0, 3'h0);
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    tb = $urandom & 32'hFFFFFFF0;
    rb = $urandom & 32'hFFFFFFF0;
    wr(`DBDS_OFS_TX_BASE, tb);
    wr(`DBDS_OFS_RX_BASE, rb);
    pt(0);
    wt(1);
    chk(tx_chain_base_r, tb);
    st(3'h3, 3'h0);
    for (i = 4; i < 7; i++)
    begin
      pt(2);
      st(i[2:0], 3'h0);
    end
    p_own <= 1'b0;
    pt(2);
    fl[0] = 1'b1;
    st(3'h1, 3'h0);
    chk(tx_chain_base_r, tb + `DBDS_DESC_BYTES);
    wt(1);
    fl[2] = 1'b1;
    st(3'h7, 3'h0);
    p_own <= 1'b1;
    p_setup <= 1'b1;
    pt(0);
    wt(1);
    st(3'h2, 3'h0);
    p_own <= 1'b0;
    pt(2);
    st(3'h6, 3'h0);
    pt(1);
    wt(0);
    chk(rx_chain_base_r, rb);
    st(3'h6, 3'h6);
    p_own <= 1'b1;
    pt(1);
    wt(0);
    st(3'h6, 3'h2);
    pt(4);
    st(3'h6, 3'h3);
    pt(3);
    st(3'h6, 3'h5);
    p_own <= 1'b0;
    pt(3);
    fl[6] = 1'b1;
    wt(0);
    chk(rx_chain_base_r, rb + `DBDS_DESC_BYTES);
    st(3'h6, 3'h6);
    pt(4);
    st(3'h6, 3'h7);
    pt(3);
    st(3'h6, 3'h6);
    wr(`DBDS_OFS_STATUS, 32'hFFFFC000);
    st(3'h6, 3'h6);
    wr(`DBDS_OFS_STATUS, 32'h00000045);
    fl = fl & ~14'h0045;
    st(3'h6, 3'h6);
    for (i = 0; i < 3; i++)
    begin
      bus_fault_code <= i[2:0];
      pt(5);
      kd = i[2:0];
      fl[13] = 1'b1;
      st(3'h6, 3'h6);
      wr(`DBDS_OFS_STATUS, 32'h00002000);
      fl[13] = 1'b0;
      st(3'h6, 3'h6);
    end
    mem_rvalid <= 1'b1;
    mem_rdata <= $urandom;
    for (i = 0; i < 80; i++)
    begin
      @(posedge clock);
      if (mem_rready === 1'b1)
      begin
        dq.push_back(mem_rdata);
        mem_rdata <= $urandom;
      end
    end
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    chk({31'h0, mem_rready}, 32'h0);
    for (i = 0; i < 300; i++)
    begin
      @(posedge clock);
      data_out_ready <= 1'($urandom % 2);
    end
    chk(dq.size(), 32'h0);
    chk({31'h0, mem_rready}, 32'h1);
    end_sim;
  end
endmodule // dbds_top_test
